// ### tch_cfg.svh
// register offsets, field positions, reset values and counts of the coprocessor host interface
// What this block does
// - sixteen channels 0..15, each with its own block of shared parameter storage
// - emulation bit set in either config register blocks host microcode access
// - microengine fetches from exactly one source, built-in rom or dual-port ram
// - instruction space totals 8K, split into selectable 2K banks
// - built-in rom holds 4K as two 2K banks
// - fetch source and active bank come from host-written config fields
// - entry table maps function number to 16 slots of 16 sub-entries
// - host sequence field selects four of the sixteen sub-entries
// - any channel accepts any function number in the four function select registers
// - scheduler serves channels at a rate set by their priority
// - priority zero disables; nonzero enables; rewrite changes level while running
// - irq level is bank select times eight plus level field 0-7
// - finished service returns that channel's host service request field to zero unless a host write to that field lands the same cycle
// - per-channel irq enable; only enabled channels raise requests
// - per-channel irq flag set on channel event, cleared by host
// - host service request code passes to the function uninterpreted
// - each function select register holds four channels; last holds 3,2,1,0
`ifndef TCH_CFG_SVH
`define TCH_CFG_SVH
`define TCH_OFF_MCR 12'h000
`define TCH_OFF_MCR2 12'h004
`define TCH_OFF_ICR 12'h008
`define TCH_OFF_IEN 12'h00c
`define TCH_OFF_IST 12'h010
`define TCH_OFF_CFS0 12'h014
`define TCH_OFF_HSQ0 12'h024
`define TCH_OFF_HSR0 12'h02c
`define TCH_OFF_PRI0 12'h034
`define TCH_OFF_STAT 12'h03c
`define TCH_OFF_UADR 12'h040
`define TCH_OFF_UDAT 12'h044
`define TCH_OFF_PRAM 12'h100
`define TCH_OFF_PRAM_LAST 12'h1fc
`define TCH_MCR_EMU 0
`define TCH_MCR_TB1 2:1
`define TCH_MCR_TB2 4:3
`define TCH_MCR2_EMU 0
`define TCH_MCR2_SRC 1
`define TCH_MCR2_BANK 3:2
`define TCH_ICR_LVL 2:0
`define TCH_ICR_BANK 4:3
`define TCH_RST_MCR 5'h00
`define TCH_RST_MCR2 4'h0
`define TCH_RST_ICR 5'h00
`define TCH_RST_IST 16'h0000
`define TCH_RST_UADR 13'h0000
`define TCH_BANK_SHIFT 11
`define TCH_PRAM_WORDS 64
`define TCH_PHASE_LAST 3'h6
`endif

// ### tch_host_if.sv
// apb register bank between host and timing coprocessor
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "tch_cfg.svh"
module tch_host_if (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic step_i,
  input wire logic svc_done_i,
  input wire logic [3:0] svc_chan_i,
  input wire logic [15:0] chan_irq_i,
  input wire logic [5:0] cp_addr_i,
  input wire logic cp_we_i,
  input wire logic [31:0] cp_wdata_i,
  output logic [31:0] cp_rdata_o,
  input wire logic [31:0] ucode_rdata_i,
  output logic [12:0] ucode_addr_o,
  output logic ucode_we_o,
  output logic [31:0] ucode_wdata_o,
  output tch_pkg::tch_chan_cfg_t [15:0] chan_cfg_o,
  output tch_pkg::tch_grant_t grant_o,
  output tch_pkg::tch_fetch_t fetch_o,
  output logic [1:0] tb1_presc_o,
  output logic [1:0] tb2_presc_o,
  output logic irq_o,
  output logic [4:0] irq_level_o
);
  tch_pkg::tch_apb_st_t st_q, st_d;
  logic pready_d;
  logic pslverr_d;
  logic [31:0] prdata_d;
  logic [4:0] mcr_q, mcr_d;
  logic [3:0] mcr2_q, mcr2_d;
  logic [4:0] icr_q, icr_d;
  logic [15:0] ist_q, ist_d;
  tch_pkg::tch_chan_cfg_t [15:0] cfg_d;
  logic [12:0] uadr_d;
  logic uwe_d;
  logic [31:0] uwd_d;
  tch_pkg::tch_grant_t grant_d;
  tch_pkg::tch_fetch_t fetch_d;
  logic irq_d;
  logic [4:0] lvl_d;
  logic [11:0] a;
  logic emu_blk;
  logic in_pram;
  logic done;
  logic wr_go;
  logic [31:0] rd;
  logic hit;
  logic blk;
  logic [31:0] pram_rd;
  logic [31:0] prio_vec;
  logic sch_valid;
  logic [3:0] sch_chan;

  // word offset n registers above a group base
  function automatic logic [11:0] woff(input logic [11:0] base, input int n);
    return base + 12'(4 * n);
  endfunction

  assign a = {paddr_i[11:2], 2'b00};
  assign emu_blk = mcr_q[`TCH_MCR_EMU] | mcr2_q[`TCH_MCR2_EMU];
  assign in_pram = a >= `TCH_OFF_PRAM && a <= `TCH_OFF_PRAM_LAST;
  assign done = st_q == tch_pkg::TCH_ST_RESP && psel_i && penable_i;
  // refused accesses leave every register untouched
  assign wr_go = done && pwrite_i && !pslverr_o;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_prio
      assign prio_vec[2*g +: 2] = chan_cfg_o[g].prio;
    end
  endgenerate

  tch_param_ram u_pram (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .a_addr_i(a[7:2]),
    .a_we_i(wr_go && in_pram),
    .a_wdata_i(pwdata_i),
    .a_rdata_o(pram_rd),
    .b_addr_i(cp_addr_i),
    .b_we_i(cp_we_i),
    .b_wdata_i(cp_wdata_i),
    .b_rdata_o(cp_rdata_o)
  );

  tch_sched u_sched (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .prio_i(prio_vec),
    .step_i(step_i),
    .grant_valid_o(sch_valid),
    .grant_chan_o(sch_chan)
  );

  // read decode
  always_comb begin
    rd = 32'h0;
    hit = 1'b1;
    blk = 1'b0;
    if (a == `TCH_OFF_MCR) begin
      rd[4:0] = mcr_q;
    end else if (a == `TCH_OFF_MCR2) begin
      rd[3:0] = mcr2_q;
    end else if (a == `TCH_OFF_ICR) begin
      rd[4:0] = icr_q;
      rd[12:8] = irq_level_o;
    end else if (a == `TCH_OFF_IEN) begin
      for (int c = 0; c < 16; c++) rd[c] = chan_cfg_o[c].irq_en;
    end else if (a == `TCH_OFF_IST) begin
      rd[15:0] = ist_q;
    end else if (a >= `TCH_OFF_CFS0 && a <= woff(`TCH_OFF_CFS0, 3)) begin
      for (int c = 0; c < 16; c++) begin
        if (a == woff(`TCH_OFF_CFS0, 3 - c / 4)) rd[4*(c%4) +: 4] = chan_cfg_o[c].func;
      end
    end else if (a >= `TCH_OFF_HSQ0 && a <= woff(`TCH_OFF_PRI0, 1)) begin
      for (int c = 0; c < 16; c++) begin
        if (a == woff(`TCH_OFF_HSQ0, 1 - c / 8)) rd[2*(c%8) +: 2] = chan_cfg_o[c].hsq;
        if (a == woff(`TCH_OFF_HSR0, 1 - c / 8)) rd[2*(c%8) +: 2] = chan_cfg_o[c].hsr;
        if (a == woff(`TCH_OFF_PRI0, 1 - c / 8)) rd[2*(c%8) +: 2] = chan_cfg_o[c].prio;
      end
    end else if (a == `TCH_OFF_STAT) begin
      rd = {24'h0, irq_o, emu_blk, fetch_o.src_ram, grant_o.valid, grant_o.chan};
    end else if (a == `TCH_OFF_UADR) begin
      rd[12:0] = ucode_addr_o;
    end else if (a == `TCH_OFF_UDAT) begin
      rd = ucode_rdata_i;
      blk = emu_blk;
    end else if (in_pram) begin
      rd = pram_rd;
    end else begin
      hit = 1'b0;
    end
  end

  // apb handshake: setup, one prepare cycle, then pready until taken
  always_comb begin
    st_d = st_q;
    pready_d = pready_o;
    pslverr_d = pslverr_o;
    prdata_d = prdata_o;
    case (st_q)
      tch_pkg::TCH_ST_IDLE: begin
        if (psel_i && !penable_i) st_d = tch_pkg::TCH_ST_PREP;
      end
      tch_pkg::TCH_ST_PREP: begin
        st_d = tch_pkg::TCH_ST_RESP;
        pready_d = 1'b1;
        pslverr_d = !hit || blk;
        prdata_d = (pwrite_i || !hit || blk) ? 32'h0 : rd;
      end
      tch_pkg::TCH_ST_RESP: begin
        if (psel_i && penable_i) begin
          st_d = tch_pkg::TCH_ST_IDLE;
          pready_d = 1'b0;
          pslverr_d = 1'b0;
        end
      end
      default: st_d = tch_pkg::TCH_ST_IDLE;
    endcase
  end

  // register writes and hardware updates
  always_comb begin
    mcr_d = mcr_q;
    mcr2_d = mcr2_q;
    icr_d = icr_q;
    cfg_d = chan_cfg_o;
    uadr_d = ucode_addr_o;
    uwe_d = 1'b0;
    uwd_d = ucode_wdata_o;
    for (int c = 0; c < 16; c++) begin
      if (svc_done_i && svc_chan_i == 4'(c)) cfg_d[c].hsr = 2'h0;
    end
    ist_d = ist_q;
    if (wr_go) begin
      if (a == `TCH_OFF_MCR) begin
        mcr_d = pwdata_i[4:0];
      end else if (a == `TCH_OFF_MCR2) begin
        mcr2_d = pwdata_i[3:0];
      end else if (a == `TCH_OFF_ICR) begin
        icr_d = pwdata_i[4:0];
      end else if (a == `TCH_OFF_IEN) begin
        for (int c = 0; c < 16; c++) cfg_d[c].irq_en = pwdata_i[c];
      end else if (a == `TCH_OFF_IST) begin
        ist_d = ist_q & ~pwdata_i[15:0];
      end else if (a == `TCH_OFF_UADR) begin
        uadr_d = pwdata_i[12:0];
      end else if (a == `TCH_OFF_UDAT) begin
        uwe_d = 1'b1;
        uwd_d = pwdata_i;
        uadr_d = ucode_addr_o + 13'h1;
      end else begin
        for (int c = 0; c < 16; c++) begin
          if (a == woff(`TCH_OFF_CFS0, 3 - c / 4)) begin
            cfg_d[c].func = pwdata_i[4*(c%4) +: 4];
          end
          if (a == woff(`TCH_OFF_HSQ0, 1 - c / 8)) begin
            cfg_d[c].hsq = pwdata_i[2*(c%8) +: 2];
          end
          if (a == woff(`TCH_OFF_HSR0, 1 - c / 8)) begin
            cfg_d[c].hsr = pwdata_i[2*(c%8) +: 2];
          end
          if (a == woff(`TCH_OFF_PRI0, 1 - c / 8)) begin
            cfg_d[c].prio = pwdata_i[2*(c%8) +: 2];
          end
        end
      end
    end
    // a read of the data port also steps the address
    if (done && !pwrite_i && !pslverr_o && a == `TCH_OFF_UDAT) uadr_d = ucode_addr_o + 13'h1;
    // channel event sets its flag; set beats a same-cycle host clear
    ist_d = ist_d | chan_irq_i;
  end

  // derived outputs toward the microengine and interrupt controller
  always_comb begin
    fetch_d.src_ram = mcr2_q[`TCH_MCR2_SRC];
    // rom holds only two banks, so the upper bank bit is dropped there
    fetch_d.bank = mcr2_q[`TCH_MCR2_SRC] ? mcr2_q[`TCH_MCR2_BANK] :
                   {1'b0, mcr2_q[2]};
    fetch_d.base = 13'({fetch_d.bank, 11'h000});
    irq_d = |(ist_q & {chan_cfg_o[15].irq_en, chan_cfg_o[14].irq_en, chan_cfg_o[13].irq_en,
                       chan_cfg_o[12].irq_en, chan_cfg_o[11].irq_en, chan_cfg_o[10].irq_en,
                       chan_cfg_o[9].irq_en, chan_cfg_o[8].irq_en, chan_cfg_o[7].irq_en,
                       chan_cfg_o[6].irq_en, chan_cfg_o[5].irq_en, chan_cfg_o[4].irq_en,
                       chan_cfg_o[3].irq_en, chan_cfg_o[2].irq_en, chan_cfg_o[1].irq_en,
                       chan_cfg_o[0].irq_en});
    lvl_d = {icr_q[`TCH_ICR_BANK], icr_q[`TCH_ICR_LVL]};
    grant_d.valid = sch_valid;
    grant_d.chan = sch_chan;
    grant_d.func = chan_cfg_o[sch_chan].func;
    grant_d.hsq = chan_cfg_o[sch_chan].hsq;
    grant_d.hsr = chan_cfg_o[sch_chan].hsr;
    grant_d.entry = {chan_cfg_o[sch_chan].func, 2'b00, chan_cfg_o[sch_chan].hsq};
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= tch_pkg::TCH_ST_IDLE;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      st_q <= st_d;
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
      prdata_o <= prdata_d;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      mcr_q <= `TCH_RST_MCR;
      mcr2_q <= `TCH_RST_MCR2;
      icr_q <= `TCH_RST_ICR;
      ist_q <= `TCH_RST_IST;
      chan_cfg_o <= '0;
      ucode_addr_o <= `TCH_RST_UADR;
      ucode_we_o <= 1'b0;
      ucode_wdata_o <= 32'h0;
    end else begin
      mcr_q <= mcr_d;
      mcr2_q <= mcr2_d;
      icr_q <= icr_d;
      ist_q <= ist_d;
      chan_cfg_o <= cfg_d;
      ucode_addr_o <= uadr_d;
      ucode_we_o <= uwe_d;
      ucode_wdata_o <= uwd_d;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      fetch_o <= '0;
      irq_o <= 1'b0;
      irq_level_o <= 5'h00;
      grant_o <= '0;
      tb1_presc_o <= 2'h0;
      tb2_presc_o <= 2'h0;
    end else begin
      fetch_o <= fetch_d;
      irq_o <= irq_d;
      irq_level_o <= lvl_d;
      grant_o <= grant_d;
      tb1_presc_o <= mcr_q[`TCH_MCR_TB1];
      tb2_presc_o <= mcr_q[`TCH_MCR_TB2];
    end
  end
endmodule

// ### tch_host_if_assertions.sv
// concurrent checks on the host interface ports
`timescale 1ns/1ps
module tch_host_if_assertions (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic step_i,
  input wire logic svc_done_i,
  input wire logic [3:0] svc_chan_i,
  input wire logic [15:0] chan_irq_i,
  input wire logic ucode_we_o,
  input wire tch_pkg::tch_chan_cfg_t [15:0] chan_cfg_o,
  input wire tch_pkg::tch_grant_t grant_o,
  input wire tch_pkg::tch_fetch_t fetch_o,
  input wire logic irq_o
);
  logic [15:0] ien;
  logic udat_done;
  tch_pkg::tch_chan_cfg_t [15:0] cfg_q;
  always_comb begin
    for (int c = 0; c < 16; c++) ien[c] = chan_cfg_o[c].irq_en;
  end
  // config one cycle back: what the grant register was loaded from
  always_ff @(posedge mclk_i) begin
    cfg_q <= chan_cfg_o;
  end
  assign udat_done = pready_o && pwrite_i && !pslverr_o && paddr_i[11:2] == 10'h011;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  a_ready_after_setup: assert property (
    psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("pready not in second access cycle");
  a_ready_one_cycle: assert property (
    pready_o && psel_i && penable_i |=> !pready_o)
    else $error("pready held after transfer taken");
  a_write_rdata_zero: assert property (
    pready_o && pwrite_i |-> prdata_o == 32'h0)
    else $error("read data not zero on write");
  a_grant_from_step: assert property (
    grant_o.valid |-> $past(step_i, 2))
    else $error("grant without step two cycles earlier");
  a_grant_entry: assert property (
    grant_o.valid |-> grant_o.func == cfg_q[grant_o.chan].func &&
      grant_o.hsq == cfg_q[grant_o.chan].hsq && grant_o.hsr == cfg_q[grant_o.chan].hsr &&
      grant_o.entry == {cfg_q[grant_o.chan].func, 2'b00, cfg_q[grant_o.chan].hsq})
    else $error("grant entry point wrong");
  a_irq_raised: assert property (
    |(chan_irq_i & ien) |-> ##2 irq_o)
    else $error("enabled channel event gave no interrupt");
  a_hsr_cleared: assert property (
    svc_done_i && !pready_o |=> chan_cfg_o[$past(svc_chan_i)].hsr == 2'b00)
    else $error("service request not cleared on completion");
  a_rom_two_banks: assert property (
    !fetch_o.src_ram |-> !fetch_o.bank[1])
    else $error("rom source with bank above one");
  a_bank_base: assert property (
    fetch_o.base == {fetch_o.bank, 11'h000})
    else $error("fetch base not bank times 2K");
  a_ucode_guard: assert property (
    ucode_we_o |-> $past(udat_done))
    else $error("microcode write without accepted data write");
  c_grant: cover property (grant_o.valid);
  c_ucode_write: cover property (ucode_we_o);
  c_refused: cover property (pready_o && pslverr_o);
endmodule

bind tch_host_if tch_host_if_assertions u_tch_host_if_assertions (.mclk_i, .reset_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .step_i,
  .svc_done_i, .svc_chan_i, .chan_irq_i, .ucode_we_o, .chan_cfg_o, .grant_o, .fetch_o,
  .irq_o);

// ### tch_host_if_tb.sv
// self-checking bench for the coprocessor host interface
`timescale 1ns/1ps
`include "tch_cfg.svh"
module tch_host_if_tb;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, cp_wdata_i = 32'h0, prdata_o, cp_rdata_o;
  logic [31:0] ucode_rdata_i, ucode_wdata_o, rd, dat;
  logic step_i = 1'b0, svc_done_i = 1'b0, cp_we_i = 1'b0;
  logic [3:0] svc_chan_i = 4'h0;
  logic [15:0] chan_irq_i = 16'h0;
  logic [5:0] cp_addr_i = 6'h00;
  logic pready_o, pslverr_o, ucode_we_o, irq_o, er, got;
  logic [12:0] ucode_addr_o;
  logic [1:0] tb1_presc_o, tb2_presc_o;
  logic [4:0] irq_level_o;
  tch_pkg::tch_chan_cfg_t [15:0] chan_cfg_o;
  tch_pkg::tch_grant_t grant_o;
  tch_pkg::tch_fetch_t fetch_o;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  tch_host_if u_tch_host_if (.mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .step_i, .svc_done_i, .svc_chan_i,
    .chan_irq_i, .cp_addr_i, .cp_we_i, .cp_wdata_i, .cp_rdata_o, .ucode_rdata_i,
    .ucode_addr_o, .ucode_we_o, .ucode_wdata_o, .chan_cfg_o, .grant_o, .fetch_o,
    .tb1_presc_o, .tb2_presc_o, .irq_o, .irq_level_o);
  tch_ucode_mem u_tch_ucode_mem (.mclk_i, .addr_i(ucode_addr_o), .we_i(ucode_we_o),
    .wdata_i(ucode_wdata_o), .rdata_o(ucode_rdata_i));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run needs a few hundred cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
    chk(nm, 32'(er), 32'h0);
  endtask

  // one step request, then watch for the single grant pulse
  task automatic step_grant();
    got = 1'b0;
    @(posedge mclk_i);
    step_i <= 1'b1;
    @(posedge mclk_i);
    step_i <= 1'b0;
    repeat (4) begin
      @(posedge mclk_i);
      if (grant_o.valid === 1'b1) begin
        got = 1'b1;
        dat = {18'h0, grant_o.hsr, grant_o.chan, grant_o.entry};
      end
    end
  endtask

  initial begin
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    rdchk("mcr_rst", `TCH_OFF_MCR, 32'h0);
    rdchk("ist_rst", `TCH_OFF_IST, 32'h0);
    wr(`TCH_OFF_UADR, 32'h5);
    wr(`TCH_OFF_UDAT, 32'h1234abcd);
    tick(2);
    chk("umem", u_tch_ucode_mem.mem[5], 32'h1234abcd);
    wr(`TCH_OFF_UADR, 32'h5);
    rdchk("udat", `TCH_OFF_UDAT, 32'h1234abcd);
    wr(`TCH_OFF_MCR, 32'h0c);
    wr(`TCH_OFF_MCR2, 32'he);
    tick(2);
    chk("tb1", 32'(tb1_presc_o), 32'h2);
    chk("tb2", 32'(tb2_presc_o), 32'h1);
    chk("fetch_ram", 32'(fetch_o), 32'({1'b1, 2'b11, 13'h1800}));
    wr(`TCH_OFF_MCR2, 32'hc);
    tick(2);
    chk("fetch_rom", 32'(fetch_o), 32'({1'b0, 2'b01, 13'h0800}));
    for (int b = 0; b < 4; b++) begin
      wr(`TCH_OFF_ICR, 32'(b * 8 + 5));
      tick(2);
      chk("irq_level", 32'(irq_level_o), 32'(b * 8 + 5));
      rdchk("icr", `TCH_OFF_ICR, 32'((b * 8 + 5) * 257));
    end
    // init order: function, sequence, request, enable, parameters, priority
    for (int n = 0; n < 4; n++) begin
      dat = 32'h0;
      for (int k = 0; k < 4; k++) dat[4*k+:4] = 4'((4 * (3 - n) + k) * 7 + 3);
      wr(`TCH_OFF_CFS0 + 12'(4 * n), dat);
    end
    wr(`TCH_OFF_HSQ0, 32'h4);
    wr(`TCH_OFF_HSQ0 + 12'h4, 32'h2);
    wr(`TCH_OFF_HSR0 + 12'h4, 32'h1);
    wr(`TCH_OFF_IEN, 32'h4);
    wr(`TCH_OFF_PRAM_LAST, 32'hcafe0f0f);
    wr(`TCH_OFF_PRI0 + 12'h4, 32'h3);
    tick(2);
    for (int c = 0; c < 16; c++) chk("func", 32'(chan_cfg_o[c].func), 32'((c * 7 + 3) % 16));
    chk("hsq9", 32'(chan_cfg_o[9].hsq), 32'h1);
    chk("prio0", 32'(chan_cfg_o[0].prio), 32'h3);
    step_grant();
    chk("grant", dat, 32'({2'b01, 4'h0, 4'h3, 2'b00, 2'b10}));
    wr(`TCH_OFF_PRI0 + 12'h4, 32'h1);
    step_grant();
    chk("granted_low", 32'(got), 32'h1);
    wr(`TCH_OFF_PRI0 + 12'h4, 32'h0);
    step_grant();
    chk("granted_off", 32'(got), 32'h0);
    @(posedge mclk_i);
    svc_done_i <= 1'b1;
    @(posedge mclk_i);
    svc_done_i <= 1'b0;
    rdchk("hsr", `TCH_OFF_HSR0 + 12'h4, 32'h0);
    // channel 0 stopped and its request cleared, so it may take a new function
    wr(`TCH_OFF_CFS0 + 12'hc, 32'h7);
    tick(2);
    chk("refunc", 32'(chan_cfg_o[0].func), 32'h7);
    @(posedge mclk_i);
    chan_irq_i <= 16'hc;
    @(posedge mclk_i);
    chan_irq_i <= 16'h0;
    tick(2);
    chk("irq_on", 32'(irq_o), 32'h1);
    rdchk("ist", `TCH_OFF_IST, 32'hc);
    wr(`TCH_OFF_IST, 32'h4);
    tick(2);
    chk("irq_off", 32'(irq_o), 32'h0);
    rdchk("ist_clr", `TCH_OFF_IST, 32'h8);
    @(posedge mclk_i);
    cp_addr_i <= 6'd63;
    tick(2);
    chk("cp_rd", cp_rdata_o, 32'hcafe0f0f);
    cp_we_i <= 1'b1;
    cp_addr_i <= 6'd0;
    cp_wdata_i <= 32'h5a5a0001;
    @(posedge mclk_i);
    cp_we_i <= 1'b0;
    rdchk("pram0", `TCH_OFF_PRAM, 32'h5a5a0001);
    wr(`TCH_OFF_MCR2, 32'hd);
    apb(1'b1, `TCH_OFF_UDAT, 32'hffffffff);
    chk("blk_w", 32'(er), 32'h1);
    wr(`TCH_OFF_MCR2, 32'hc);
    wr(`TCH_OFF_MCR, 32'h1);
    apb(1'b0, `TCH_OFF_UDAT, 32'h0);
    chk("blk_r", 32'(er), 32'h1);
    chk("blk_rd", rd, 32'h0);
    chk("blk_adr", 32'(ucode_addr_o), 32'h6);
    rdchk("stat", `TCH_OFF_STAT, 32'h40);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'(er), 32'h1);
    complete_run();
  end
endmodule

// ### tch_param_ram.sv
// two-port parameter storage, 16 channels of four words, registered reads
`timescale 1ns/1ps
`include "tch_cfg.svh"
module tch_param_ram (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [5:0] a_addr_i,
  input wire logic a_we_i,
  input wire logic [31:0] a_wdata_i,
  output logic [31:0] a_rdata_o,
  input wire logic [5:0] b_addr_i,
  input wire logic b_we_i,
  input wire logic [31:0] b_wdata_i,
  output logic [31:0] b_rdata_o
);
  logic [31:0] mem_q [`TCH_PRAM_WORDS];

  // same-word collision: the coprocessor port wins
  always_ff @(posedge mclk_i) begin
    if (a_we_i && !(b_we_i && b_addr_i == a_addr_i)) begin
      mem_q[a_addr_i] <= a_wdata_i;
    end
    if (b_we_i) begin
      mem_q[b_addr_i] <= b_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      a_rdata_o <= 32'h0;
      b_rdata_o <= 32'h0;
    end else begin
      a_rdata_o <= mem_q[a_addr_i];
      b_rdata_o <= mem_q[b_addr_i];
    end
  end
endmodule

// ### tch_pkg.sv
// types shared by the coprocessor host interface files
package tch_pkg;
  typedef struct packed {
    logic [3:0] func;
    logic [1:0] hsq;
    logic [1:0] hsr;
    logic [1:0] prio;
    logic irq_en;
  } tch_chan_cfg_t;
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [3:0] func;
    logic [1:0] hsq;
    logic [1:0] hsr;
    logic [7:0] entry;
  } tch_grant_t;
  typedef struct packed {
    logic src_ram;
    logic [1:0] bank;
    logic [12:0] base;
  } tch_fetch_t;
  typedef enum logic [1:0] {
    TCH_ST_IDLE,
    TCH_ST_PREP,
    TCH_ST_RESP
  } tch_apb_st_t;
endpackage

// ### tch_sched.sv
// weighted round-robin channel scheduler driven by channel priorities
`timescale 1ns/1ps
`include "tch_cfg.svh"
module tch_sched (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [31:0] prio_i,
  input wire logic step_i,
  output logic grant_valid_o,
  output logic [3:0] grant_chan_o
);
  logic [15:0] en_mask;
  logic [15:0] cls_mask;
  logic [1:0] cls;
  logic [2:0] phase_q, phase_d;
  logic [3:0] ptr_q, ptr_d;
  logic valid_d;
  logic [3:0] chan_d;
  logic [4:0] pick_c;
  logic [4:0] pick_a;

  // {found, index} of first set bit at or after start, wrapping
  function automatic logic [4:0] rr_pick(input logic [15:0] m, input logic [3:0] start);
    logic [4:0] r;
    logic [3:0] idx;
    r = 5'h00;
    for (int k = 15; k >= 0; k--) begin
      idx = start + 4'(k);
      if (m[idx]) r = {1'b1, idx};
    end
    return r;
  endfunction

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_mask
      assign en_mask[g] = prio_i[2*g +: 2] != 2'h0;
      assign cls_mask[g] = prio_i[2*g +: 2] == cls;
    end
  endgenerate

  // high class gets 4 of 7 slots, middle 2, low 1; idle slots fall to any enabled
  always_comb begin
    case (phase_q)
      3'h1, 3'h5: cls = 2'h2;
      3'h3: cls = 2'h1;
      default: cls = 2'h3;
    endcase
    pick_c = rr_pick(cls_mask, ptr_q);
    pick_a = rr_pick(en_mask, ptr_q);
    phase_d = phase_q;
    ptr_d = ptr_q;
    valid_d = 1'b0;
    chan_d = grant_chan_o;
    if (step_i) begin
      phase_d = (phase_q == `TCH_PHASE_LAST) ? 3'h0 : phase_q + 3'h1;
      if (pick_c[4]) begin
        valid_d = 1'b1;
        chan_d = pick_c[3:0];
      end else if (pick_a[4]) begin
        valid_d = 1'b1;
        chan_d = pick_a[3:0];
      end
      if (valid_d) ptr_d = chan_d + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q <= 3'h0;
      ptr_q <= 4'h0;
      grant_valid_o <= 1'b0;
      grant_chan_o <= 4'h0;
    end else begin
      phase_q <= phase_d;
      ptr_q <= ptr_d;
      grant_valid_o <= valid_d;
      grant_chan_o <= chan_d;
    end
  end
endmodule

// ### tch_ucode_mem.sv
// microcode memory model on the far side of the host interface
`timescale 1ns/1ps
module tch_ucode_mem (
  input wire logic mclk_i,
  input wire logic [12:0] addr_i,
  input wire logic we_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  // whole 8K word space, so every bank the fetch base can name exists
  logic [31:0] mem [0:8191];
  logic [12:0] addr_q;
  assign rdata_o = mem[addr_i];
  // write pulse already carries the stepped address, so use last cycle's
  always @(posedge mclk_i) begin
    addr_q <= addr_i;
    if (we_i) begin
      mem[addr_q] <= wdata_i;
    end
  end
endmodule
